//--- crf_regfile.sv
`timescale 1ns/100ps

module crf_regfile (
  input  wire logic                          hclk,        // Core clock, 200 MHz.
  input  wire logic                          hresetn,     // Async reset, active low.
  input  wire logic                          hsel,        // Slave select.
  input  wire logic [31:0]                   haddr,       // Byte address.
  input  wire logic [1:0]                    htrans,      // Transfer type.
  input  wire logic                          hwrite,      // Write when high.
  input  wire logic [2:0]                    hsize,       // Transfer size.
  input  wire logic [31:0]                   hwdata,      // Write data.
  input  wire logic                          hready,      // Bus ready in.
  output logic      [31:0]                   hrdata,      // Read data.
  output logic                               hreadyout,   // Slave ready.
  output logic                               hresp,       // Always OKAY.
  input  wire logic                          alu_update,  // ALU result valid.
  input  wire logic [crf_pkg::DW-1:0]        alu_result,  // ALU result word.
  input  wire logic                          alu_carry,   // Carry, borrow or shift-out.
  input  wire logic                          alu_ovf,     // Overflow of the operation.
  input  wire logic                          pc_load,     // Core advances the counter.
  input  wire logic [crf_pkg::AW-1:0]        pc_next,     // New program counter.
  input  wire logic                          irq_req,     // Maskable request pending.
  input  wire logic [crf_pkg::LVL_W-1:0]     irq_level,   // Request priority.
  input  wire logic                          irq_ack,     // Interrupt acknowledged.
  input  wire logic                          irq_sw,      // Acknowledge is a software one.
  input  wire logic [crf_pkg::VEC_W-1:0]     irq_vec,     // Software vector number.
  output logic                               irq_accept,  // Request may be taken.
  output logic [crf_pkg::DW-1:0]             active_sp,   // Selected stack pointer.
  output logic [crf_pkg::AW-1:0]             pc_out,      // Program counter.
  output logic [crf_pkg::AW-1:0]             vtb_out      // Vector table base.
);

  localparam int DW = crf_pkg::DW;
  localparam int NB = crf_pkg::NBANK;

  // Non-banked registers.
  logic [crf_pkg::AW-1:0] vector_table_base;
  logic [crf_pkg::AW-1:0] program_counter;
  logic [DW-1:0]          user_stack_pointer;
  logic [DW-1:0]          interrupt_stack_pointer;
  logic [DW-1:0]          static_base;
  logic [crf_pkg::FW-1:0] processor_flags;

  // Bus tracking.
  crf_pkg::crf_bus_e state;
  logic [7:0]        dp_addr;
  logic              dp_write;
  logic              wr_en;
  logic [31:0]       next_rdata;

  // Bank copies and their write controls.
  logic [NB*DW-1:0] bank0_q;
  logic [NB*DW-1:0] bank1_q;
  logic [NB*DW-1:0] cur_q;
  logic [NB-1:0]    bwe;
  logic [NB-1:0]    bank0_we;
  logic [NB-1:0]    bank1_we;
  logic [1:0]       bbe;
  logic [NB*DW-1:0] bwd;

  // Named views of the selected bank.
  logic [DW-1:0] data_reg_0;
  logic [DW-1:0] data_reg_1;
  logic [DW-1:0] data_reg_2;
  logic [DW-1:0] data_reg_3;
  logic [DW-1:0] address_reg_0;
  logic [DW-1:0] address_reg_1;
  logic [DW-1:0] frame_base;
  logic [2*DW-1:0] data_pair_low;
  logic [2*DW-1:0] data_pair_high;
  logic [2*DW-1:0] address_pair;

  logic bank_sel;
  logic u_sel;
  logic u_clear;
  logic [crf_pkg::LVL_W-1:0] processor_priority_level;

  // Field views of the flag register.
  assign bank_sel = processor_flags[crf_pkg::F_B];
  assign u_sel    = processor_flags[crf_pkg::F_U];
  assign processor_priority_level =
    processor_flags[crf_pkg::F_IPL +: crf_pkg::LVL_W];

  // The bank flag steers the view and the writes; both copies hold their values.
  assign cur_q = bank_sel ? bank1_q : bank0_q;

  // Slices of the selected bank.
  assign data_reg_0    = cur_q[crf_pkg::IDX_R0*DW +: DW];
  assign data_reg_1    = cur_q[crf_pkg::IDX_R1*DW +: DW];
  assign data_reg_2    = cur_q[crf_pkg::IDX_R2*DW +: DW];
  assign data_reg_3    = cur_q[crf_pkg::IDX_R3*DW +: DW];
  assign address_reg_0 = cur_q[crf_pkg::IDX_A0*DW +: DW];
  assign address_reg_1 = cur_q[crf_pkg::IDX_A1*DW +: DW];
  assign frame_base    = cur_q[crf_pkg::IDX_FB*DW +: DW];

  // Paired 32-bit operands, upper register in the high half.
  assign data_pair_low  = {data_reg_2, data_reg_0};
  assign data_pair_high = {data_reg_3, data_reg_1};
  assign address_pair   = {address_reg_1, address_reg_0};

  // Two complete copies of the banked set.
  crf_bank u_bank0 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (bank0_we),
    .be      (bbe),
    .wdata   (bwd),
    .rdata   (bank0_q)
  );

  crf_bank u_bank1 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (bank1_we),
    .be      (bbe),
    .wdata   (bwd),
    .rdata   (bank1_q)
  );

  // A write goes only to the copy chosen by the bank flag.
  assign bank0_we = bank_sel ? '0 : bwe;
  assign bank1_we = bank_sel ? bwe : '0;

  // Data phase write strobe.
  assign wr_en = (state == crf_pkg::CRF_ST_IDLE) && dp_write;

  // Address phase capture and read wait state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= crf_pkg::CRF_ST_IDLE;
      dp_addr   <= 8'h00;
      dp_write  <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      case (state)
        crf_pkg::CRF_ST_IDLE: begin
          dp_write <= 1'b0;
          if (hsel && htrans[1] && hready) begin
            dp_addr <= haddr[7:0];
            if (hwrite) begin
              dp_write <= 1'b1;
            end else begin
              state     <= crf_pkg::CRF_ST_RD;
              hreadyout <= 1'b0;
            end
          end
        end
        crf_pkg::CRF_ST_RD: begin
          state     <= crf_pkg::CRF_ST_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          state     <= crf_pkg::CRF_ST_IDLE;
          hreadyout <= 1'b1;
          dp_write  <= 1'b0;
        end
      endcase
    end
  end

  // Read data is sampled in the wait cycle, after any earlier write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (state == crf_pkg::CRF_ST_RD) begin
      hrdata <= next_rdata;
    end
  end

  // Read mux; unmapped offsets and unused upper bits read zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (dp_addr)
      crf_pkg::OFF_R0:     next_rdata[DW-1:0] = data_reg_0;
      crf_pkg::OFF_R1:     next_rdata[DW-1:0] = data_reg_1;
      crf_pkg::OFF_R2:     next_rdata[DW-1:0] = data_reg_2;
      crf_pkg::OFF_R3:     next_rdata[DW-1:0] = data_reg_3;
      crf_pkg::OFF_A0:     next_rdata[DW-1:0] = address_reg_0;
      crf_pkg::OFF_A1:     next_rdata[DW-1:0] = address_reg_1;
      crf_pkg::OFF_FB:     next_rdata[DW-1:0] = frame_base;
      crf_pkg::OFF_PAIR_L: next_rdata = data_pair_low;
      crf_pkg::OFF_PAIR_H: next_rdata = data_pair_high;
      crf_pkg::OFF_APAIR:  next_rdata = address_pair;
      crf_pkg::OFF_R0_LO:  next_rdata[7:0] = data_reg_0[7:0];
      crf_pkg::OFF_R0_HI:  next_rdata[7:0] = data_reg_0[DW-1:8];
      crf_pkg::OFF_R1_LO:  next_rdata[7:0] = data_reg_1[7:0];
      crf_pkg::OFF_R1_HI:  next_rdata[7:0] = data_reg_1[DW-1:8];
      crf_pkg::OFF_VTB:    next_rdata[crf_pkg::AW-1:0] = vector_table_base;
      crf_pkg::OFF_PC:     next_rdata[crf_pkg::AW-1:0] = program_counter;
      crf_pkg::OFF_USP:    next_rdata[DW-1:0] = user_stack_pointer;
      crf_pkg::OFF_ISP:    next_rdata[DW-1:0] = interrupt_stack_pointer;
      crf_pkg::OFF_SB:     next_rdata[DW-1:0] = static_base;
      crf_pkg::OFF_FLG:    next_rdata[crf_pkg::FW-1:0] = processor_flags;
      crf_pkg::OFF_SP:     next_rdata[DW-1:0] = active_sp;
      default:             next_rdata = 32'h0000_0000;
    endcase
  end

  // Bus writes into the banked set, whole words, pairs or byte halves.
  always_comb begin
    bwe = '0;
    bbe = 2'b11;
    bwd = '0;
    if (wr_en) begin
      case (dp_addr)
        crf_pkg::OFF_R0, crf_pkg::OFF_R1, crf_pkg::OFF_R2, crf_pkg::OFF_R3,
        crf_pkg::OFF_A0, crf_pkg::OFF_A1, crf_pkg::OFF_FB: begin
          bwe[dp_addr[4:2]] = 1'b1;
          bwd[dp_addr[4:2]*DW +: DW] = hwdata[DW-1:0];
        end
        crf_pkg::OFF_PAIR_L: begin
          bwe[crf_pkg::IDX_R0] = 1'b1;
          bwe[crf_pkg::IDX_R2] = 1'b1;
          bwd[crf_pkg::IDX_R0*DW +: DW] = hwdata[DW-1:0];
          bwd[crf_pkg::IDX_R2*DW +: DW] = hwdata[2*DW-1:DW];
        end
        crf_pkg::OFF_PAIR_H: begin
          bwe[crf_pkg::IDX_R1] = 1'b1;
          bwe[crf_pkg::IDX_R3] = 1'b1;
          bwd[crf_pkg::IDX_R1*DW +: DW] = hwdata[DW-1:0];
          bwd[crf_pkg::IDX_R3*DW +: DW] = hwdata[2*DW-1:DW];
        end
        crf_pkg::OFF_APAIR: begin
          bwe[crf_pkg::IDX_A0] = 1'b1;
          bwe[crf_pkg::IDX_A1] = 1'b1;
          bwd[crf_pkg::IDX_A0*DW +: DW] = hwdata[DW-1:0];
          bwd[crf_pkg::IDX_A1*DW +: DW] = hwdata[2*DW-1:DW];
        end
        crf_pkg::OFF_R0_LO: begin
          bwe[crf_pkg::IDX_R0] = 1'b1;
          bbe = 2'b01;
          bwd[crf_pkg::IDX_R0*DW +: DW] = {8'h00, hwdata[7:0]};
        end
        crf_pkg::OFF_R0_HI: begin
          bwe[crf_pkg::IDX_R0] = 1'b1;
          bbe = 2'b10;
          bwd[crf_pkg::IDX_R0*DW +: DW] = {hwdata[7:0], 8'h00};
        end
        crf_pkg::OFF_R1_LO: begin
          bwe[crf_pkg::IDX_R1] = 1'b1;
          bbe = 2'b01;
          bwd[crf_pkg::IDX_R1*DW +: DW] = {8'h00, hwdata[7:0]};
        end
        crf_pkg::OFF_R1_HI: begin
          bwe[crf_pkg::IDX_R1] = 1'b1;
          bbe = 2'b10;
          bwd[crf_pkg::IDX_R1*DW +: DW] = {hwdata[7:0], 8'h00};
        end
        default: begin
          bwe = '0;
        end
      endcase
    end
  end

  // Vector table base and static base are plain 20 and 16-bit words.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vector_table_base <= crf_pkg::RST_W20;
      static_base       <= crf_pkg::RST_W16;
    end else if (wr_en) begin
      if (dp_addr == crf_pkg::OFF_VTB) begin
        vector_table_base <= hwdata[crf_pkg::AW-1:0];
      end
      if (dp_addr == crf_pkg::OFF_SB) begin
        static_base <= hwdata[DW-1:0];
      end
    end
  end

  // Program counter; the core's own update wins over a bus write.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_counter <= crf_pkg::RST_W20;
    end else if (pc_load) begin
      program_counter <= pc_next;
    end else if (wr_en && dp_addr == crf_pkg::OFF_PC) begin
      program_counter <= hwdata[crf_pkg::AW-1:0];
    end
  end

  // Stack pointers, reachable directly or through the active view.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_stack_pointer      <= crf_pkg::RST_W16;
      interrupt_stack_pointer <= crf_pkg::RST_W16;
    end else if (wr_en) begin
      if (dp_addr == crf_pkg::OFF_USP || (dp_addr == crf_pkg::OFF_SP && u_sel)) begin
        user_stack_pointer <= hwdata[DW-1:0];
      end
      if (dp_addr == crf_pkg::OFF_ISP || (dp_addr == crf_pkg::OFF_SP && !u_sel)) begin
        interrupt_stack_pointer <= hwdata[DW-1:0];
      end
    end
  end

  // Stack flag drops on a hardware acknowledge or a low software vector.
  assign u_clear = irq_ack && (!irq_sw || irq_vec <= crf_pkg::SW_U_MAX);

  // Flag register: bus write first, then ALU results, then acknowledge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      processor_flags <= crf_pkg::RST_FLG;
    end else begin
      if (wr_en && dp_addr == crf_pkg::OFF_FLG) begin
        processor_flags <= hwdata[crf_pkg::FW-1:0];
      end
      if (alu_update) begin
        processor_flags[crf_pkg::F_C] <= alu_carry;
        processor_flags[crf_pkg::F_Z] <= (alu_result == '0);
        processor_flags[crf_pkg::F_S] <= alu_result[DW-1];
        processor_flags[crf_pkg::F_O] <= alu_ovf;
      end
      if (irq_ack) begin
        processor_flags[crf_pkg::F_I] <= 1'b0;
      end
      if (u_clear) begin
        processor_flags[crf_pkg::F_U] <= 1'b0;
      end
    end
  end

  // Maskable request passes only when enabled and above the level.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_accept <= 1'b0;
    end else begin
      irq_accept <= irq_req && processor_flags[crf_pkg::F_I]
                    && (irq_level > processor_priority_level);
    end
  end

  // Registered copies for the core.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_sp <= crf_pkg::RST_W16;
      pc_out    <= crf_pkg::RST_W20;
      vtb_out   <= crf_pkg::RST_W20;
    end else begin
      active_sp <= u_sel ? user_stack_pointer : interrupt_stack_pointer;
      pc_out    <= program_counter;
      vtb_out   <= vector_table_base;
    end
  end

endmodule : crf_regfile

//--- crf_pkg.sv
package crf_pkg;

  // Datapath widths.
  localparam int DW     = 16;
  localparam int AW     = 20;
  localparam int FW     = 11;
  localparam int BW     = 32;
  localparam int NBANK  = 7;
  localparam int BYTE_W = 8;
  localparam int VEC_W  = 6;
  localparam int LVL_W  = 3;

  // Slot of each register inside one bank copy.
  localparam int IDX_R0 = 0;
  localparam int IDX_R1 = 1;
  localparam int IDX_R2 = 2;
  localparam int IDX_R3 = 3;
  localparam int IDX_A0 = 4;
  localparam int IDX_A1 = 5;
  localparam int IDX_FB = 6;

  // Byte offsets of the register words on the bus.
  localparam logic [7:0] OFF_R0     = 8'h00;
  localparam logic [7:0] OFF_R1     = 8'h04;
  localparam logic [7:0] OFF_R2     = 8'h08;
  localparam logic [7:0] OFF_R3     = 8'h0c;
  localparam logic [7:0] OFF_A0     = 8'h10;
  localparam logic [7:0] OFF_A1     = 8'h14;
  localparam logic [7:0] OFF_FB     = 8'h18;
  localparam logic [7:0] OFF_PAIR_L = 8'h1c;
  localparam logic [7:0] OFF_PAIR_H = 8'h20;
  localparam logic [7:0] OFF_APAIR  = 8'h24;
  localparam logic [7:0] OFF_R0_LO  = 8'h28;
  localparam logic [7:0] OFF_R0_HI  = 8'h2c;
  localparam logic [7:0] OFF_R1_LO  = 8'h30;
  localparam logic [7:0] OFF_R1_HI  = 8'h34;
  localparam logic [7:0] OFF_VTB    = 8'h38;
  localparam logic [7:0] OFF_PC     = 8'h3c;
  localparam logic [7:0] OFF_USP    = 8'h40;
  localparam logic [7:0] OFF_ISP    = 8'h44;
  localparam logic [7:0] OFF_SB     = 8'h48;
  localparam logic [7:0] OFF_FLG    = 8'h4c;
  localparam logic [7:0] OFF_SP     = 8'h50;

  // Flag register field positions.
  localparam int F_C    = 0;
  localparam int F_D    = 1;
  localparam int F_Z    = 2;
  localparam int F_S    = 3;
  localparam int F_B    = 4;
  localparam int F_O    = 5;
  localparam int F_I    = 6;
  localparam int F_U    = 7;
  localparam int F_IPL  = 8;

  // Reset values and limits.
  localparam logic [DW-1:0]    RST_W16  = 16'h0000;
  localparam logic [AW-1:0]    RST_W20  = 20'h00000;
  localparam logic [FW-1:0]    RST_FLG  = 11'h000;
  localparam logic [VEC_W-1:0] SW_U_MAX = 6'h1f;

  // Bus slave states.
  typedef enum logic [1:0] {
    CRF_ST_IDLE = 2'b01,
    CRF_ST_RD   = 2'b10
  } crf_bus_e;

endpackage : crf_pkg

//--- crf_bank.sv
`timescale 1ns/100ps

// One complete copy of the banked registers, with byte-lane writes.
module crf_bank (
  input  wire logic                                hclk,    // Core clock.
  input  wire logic                                hresetn, // Async reset, active low.
  input  wire logic [crf_pkg::NBANK-1:0]           we,      // Write enable per slot.
  input  wire logic [1:0]                          be,      // Byte lanes to write.
  input  wire logic [crf_pkg::NBANK*crf_pkg::DW-1:0] wdata, // Write data per slot.
  output logic      [crf_pkg::NBANK*crf_pkg::DW-1:0] rdata  // Contents per slot.
);

  // Each slot keeps its value until written, whatever bank is selected.
  for (genvar g = 0; g < crf_pkg::NBANK; g++) begin : g_slot
    for (genvar b = 0; b < 2; b++) begin : g_lane
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          rdata[g*crf_pkg::DW+b*crf_pkg::BYTE_W +: crf_pkg::BYTE_W] <=
            crf_pkg::RST_W16[b*crf_pkg::BYTE_W +: crf_pkg::BYTE_W];
        end else if (we[g] && be[b]) begin
          rdata[g*crf_pkg::DW+b*crf_pkg::BYTE_W +: crf_pkg::BYTE_W] <=
            wdata[g*crf_pkg::DW+b*crf_pkg::BYTE_W +: crf_pkg::BYTE_W];
        end
      end
    end
  end

endmodule : crf_bank

//--- crf_checker.sv
`timescale 1ns/100ps

// Watches bus timing and the core-side outputs of the register file.
module crf_checker (
  input wire logic                      hclk,       // Clock.
  input wire logic                      hresetn,    // Reset, active low.
  input wire logic                      hsel,       // Select.
  input wire logic [1:0]                htrans,     // Transfer type.
  input wire logic                      hwrite,     // Write.
  input wire logic                      hready,     // Bus ready.
  input wire logic [31:0]               hrdata,     // Read data.
  input wire logic                      hreadyout,  // Slave ready.
  input wire logic                      irq_req,    // Request.
  input wire logic [crf_pkg::LVL_W-1:0] irq_level,  // Request level.
  input wire logic                      irq_ack,    // Acknowledge.
  input wire logic                      irq_accept, // Request may be taken.
  input wire logic [crf_pkg::DW-1:0]    active_sp,  // Active stack.
  input wire logic                      pc_load,    // Counter load.
  input wire logic [crf_pkg::AW-1:0]    pc_next,    // New counter.
  input wire logic [crf_pkg::AW-1:0]    pc_out,     // Counter.
  input wire logic [crf_pkg::AW-1:0]    vtb_out     // Table base.
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Transfers that the slave takes at this edge.
  logic rd_go;
  logic wr_go;
  assign rd_go = hsel && htrans[1] && hready && !hwrite;
  assign wr_go = hsel && htrans[1] && hready && hwrite;

  property p_rd_wait; rd_go |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_nowait; wr_go |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_rd_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_ack_mask; irq_ack |-> ##2 !irq_accept; endproperty
  a_ack_mask: assert property (p_ack_mask) else $error("ack left enable");
  property p_acc_cause;
    irq_accept |-> $past(irq_req) && $past(irq_level) != 3'h0;
  endproperty
  a_acc_cause: assert property (p_acc_cause) else $error("bad accept");
  property p_pc_load; pc_load |-> ##2 pc_out == $past(pc_next, 2); endproperty
  a_pc_load: assert property (p_pc_load) else $error("counter not loaded");
  property p_vtb_cause; !$stable(vtb_out) |-> $past(wr_go, 3); endproperty
  a_vtb_cause: assert property (p_vtb_cause) else $error("table base moved");
  property p_sp_cause;
    !$stable(active_sp) |-> $past(wr_go, 3) || $past(irq_ack, 2);
  endproperty
  a_sp_cause: assert property (p_sp_cause) else $error("stack moved");

  c_read: cover property (rd_go);
  c_accept: cover property (irq_accept);
  c_load: cover property (pc_load);
endmodule : crf_checker

bind crf_regfile crf_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .irq_req(irq_req),
  .irq_level(irq_level), .irq_ack(irq_ack), .irq_accept(irq_accept),
  .active_sp(active_sp), .pc_load(pc_load), .pc_next(pc_next), .pc_out(pc_out),
  .vtb_out(vtb_out)
);

//--- crf_alu_model.sv
`timescale 1ns/100ps

// Execution unit stand-in: one add or subtract, answered lat+1 cycles after go.
module crf_alu_model (
  input  wire logic        hclk,       // Clock.
  input  wire logic        hresetn,    // Reset, active low.
  input  wire logic        go,         // Start one operation.
  input  wire logic        sub,        // Subtract when high.
  input  wire logic [15:0] op_a,       // First operand.
  input  wire logic [15:0] op_b,       // Second operand.
  input  wire logic [3:0]  lat,        // Wait cycles.
  output logic             alu_update, // Result valid.
  output logic [15:0]      alu_result, // Result word.
  output logic             alu_carry,  // Carry or borrow.
  output logic             alu_ovf     // Overflow.
);
  logic [3:0]  cnt;
  logic        busy;
  logic [16:0] sum;
  logic        ovf;

  // Carry or borrow sits in bit 16; overflow from the operand signs.
  assign sum = sub ? {1'b0, op_a} - {1'b0, op_b} : {1'b0, op_a} + {1'b0, op_b};
  assign ovf = (op_a[15] ^ sum[15]) & (sub ? op_a[15] ^ op_b[15] : ~(op_a[15] ^ op_b[15]));

  // Outside the pulse result, carry and overflow toggle so that stale values never look valid.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy       <= 1'b0;
      cnt        <= 4'h0;
      alu_update <= 1'b0;
      alu_result <= 16'h0000;
      alu_carry  <= 1'b0;
      alu_ovf    <= 1'b0;
    end else begin
      alu_update <= 1'b0;
      alu_result <= ~alu_result;
      alu_carry  <= ~alu_carry;
      alu_ovf    <= ~alu_ovf;
      if (go && !busy) begin
        busy <= 1'b1;
        cnt  <= lat;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy       <= 1'b0;
        alu_update <= 1'b1;
        alu_result <= sum[15:0];
        alu_carry  <= sum[16];
        alu_ovf    <= ovf;
      end
    end
  end
endmodule : crf_alu_model

//--- cpu_register_file_flags_tb_top.sv
`timescale 1ns/100ps

module cpu_register_file_flags_tb_top;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic        pc_load = 0, irq_req = 0, irq_ack = 0, irq_sw = 0, irq_accept;
  logic        go = 0, sub = 0, alu_update, alu_carry, alu_ovf;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, v, w;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2, irq_level = 0;
  logic [15:0] op_a = 0, op_b = 0, alu_result, active_sp;
  logic [19:0] pc_next = 0, pc_out, vtb_out;
  logic [5:0]  irq_vec = 0;
  logic [3:0]  lat = 0;
  logic [7:0]  plain [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h38,
                              8'h3c, 8'h40, 8'h44, 8'h48};
  logic [5:0]  vt [5] = '{6'h3f, 6'h00, 6'h1f, 6'h20, 6'h3f};
  int          seed, fails = 0, checks_done = 0, i, k;

  assign hready = hreadyout;
  crf_regfile uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .alu_update(alu_update),
    .alu_result(alu_result), .alu_carry(alu_carry), .alu_ovf(alu_ovf),
    .pc_load(pc_load), .pc_next(pc_next), .irq_req(irq_req), .irq_level(irq_level),
    .irq_ack(irq_ack), .irq_sw(irq_sw), .irq_vec(irq_vec), .irq_accept(irq_accept),
    .active_sp(active_sp), .pc_out(pc_out), .vtb_out(vtb_out)
  );
  crf_alu_model alu (
    .hclk(hclk), .hresetn(hresetn), .go(go), .sub(sub), .op_a(op_a), .op_b(op_b),
    .lat(lat), .alu_update(alu_update), .alu_result(alu_result),
    .alu_carry(alu_carry), .alu_ovf(alu_ovf)
  );

  // Free-running core clock.
  always #2.5 hclk = ~hclk;

  // Compares one value and counts any mismatch.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop;
    if (fails == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // One single AHB transfer; read data lands in rd.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
    check({31'h0, hresp}, 32'h0);
  endtask : rdc

  function automatic logic [31:0] msk(input logic [7:0] a);
    if (a == 8'h38 || a == 8'h3c) return 32'h000f_ffff;
    return 32'h0000_ffff;
  endfunction : msk

  // Expected C, Z, S and O bits of the flag word after one operation.
  function automatic logic [31:0] alu_exp(input logic [15:0] x, y, input logic s);
    logic [16:0] r;
    logic        o;
    r = s ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
    o = (x[15] ^ (s ? ~y[15] : y[15])) ? 1'b0 : r[15] ^ x[15];
    return {26'h0, o, 1'b0, r[15], r[15:0] == 16'h0, 1'b0, r[16]};
  endfunction : alu_exp

  // Cuts a hang short.
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    seed = 98648;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (i = 0; i < 64; i++) rdc(8'(i * 4), 32'h0);
    repeat (4) foreach (plain[k]) begin
      v = $random(seed);
      bus(1'b1, plain[k], v);
      if (plain[k] == 8'h38) w = v;
      rdc(plain[k], v & msk(plain[k]));
    end
    check(32'(vtb_out), w & 32'h000f_ffff);
    for (k = 0; k < 3; k++) begin
      v = $random(seed);
      w = $random(seed);
      bus(1'b1, 8'h1c + 8'(k * 4), v);
      rdc(8'(k * 4) + ((k == 2) ? 8'h08 : 8'h00), v & 32'hffff);
      rdc(8'(k * 4) + ((k == 2) ? 8'h0c : 8'h08), v >> 16);
      bus(1'b1, 8'(k * 4) + ((k == 2) ? 8'h08 : 8'h00), w);
      rdc(8'h1c + 8'(k * 4), {v[31:16], w[15:0]});
    end
    for (k = 0; k < 4; k++) begin
      v = $random(seed);
      w = $random(seed);
      bus(1'b1, (k < 2) ? 8'h00 : 8'h04, v);
      bus(1'b1, 8'h28 + 8'(k * 4), w);
      rdc(8'h28 + 8'(k * 4), w & 32'hff);
      rdc((k < 2) ? 8'h00 : 8'h04, k[0] ? {16'h0, w[7:0], v[7:0]} : {16'h0, v[15:8], w[7:0]});
    end
    v = $random(seed);
    w = $random(seed);
    bus(1'b1, 8'h00, v);
    bus(1'b1, 8'h4c, 32'h10);
    bus(1'b1, 8'h00, w);
    rdc(8'h00, w & 32'hffff);
    bus(1'b1, 8'h4c, 32'h0);
    rdc(8'h00, v & 32'hffff);
    bus(1'b1, 8'h4c, 32'h10);
    rdc(8'h00, w & 32'hffff);
    v = $random(seed) & 32'hffff_f7fd;
    bus(1'b1, 8'h4c, v);
    rdc(8'h4c, v & 32'h7fd);
    bus(1'b1, 8'h4c, 32'h0);
    for (k = 0; k < 12; k++) begin
      op_a <= (k == 0) ? 16'h8000 : 16'($random(seed));
      op_b <= (k == 0) ? 16'h8000 : 16'($random(seed));
      sub  <= k[0];
      lat  <= 4'($random(seed) & 3);
      go   <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      if (k == 1) op_b <= op_a;
      i = 0;
      while (alu_update !== 1'b1 && i < 20) begin
        @(posedge hclk);
        i++;
      end
      check(32'(i < 20), 32'h1);
      rdc(8'h4c, alu_exp(op_a, op_b, sub));
      bus(1'b1, 8'h4c, 32'h0);
    end
    irq_req <= 1'b1;
    for (k = 0; k < 9; k++) begin
      bus(1'b1, 8'h4c, (k == 8) ? 32'h300 : 32'h340);
      irq_level <= (k == 8) ? 3'h7 : 3'(k);
      repeat (2) @(posedge hclk);
      check(32'(irq_accept), 32'(k > 3 && k < 8));
    end
    for (k = 0; k < 5; k++) begin
      bus(1'b1, 8'h4c, 32'h0c0);
      irq_sw  <= (k != 0);
      irq_vec <= vt[k];
      irq_ack <= 1'b1;
      @(posedge hclk);
      irq_ack <= 1'b0;
      rdc(8'h4c, (k > 2) ? 32'h080 : 32'h0);
    end
    irq_req <= 1'b0;
    v = $random(seed);
    w = $random(seed);
    bus(1'b1, 8'h40, v);
    bus(1'b1, 8'h44, w);
    bus(1'b1, 8'h4c, 32'h080);
    rdc(8'h50, v & 32'hffff);
    check(32'(active_sp), v & 32'hffff);
    bus(1'b1, 8'h4c, 32'h0);
    rdc(8'h50, w & 32'hffff);
    check(32'(active_sp), w & 32'hffff);
    bus(1'b1, 8'h50, v);
    rdc(8'h44, v & 32'hffff);
    v = $random(seed) & 32'hfffff;
    pc_next <= v[19:0];
    pc_load <= 1'b1;
    @(posedge hclk);
    pc_load <= 1'b0;
    repeat (2) @(posedge hclk);
    check(32'(pc_out), v);
    rdc(8'h3c, v);
    report_and_stop();
  end
endmodule : cpu_register_file_flags_tb_top
